// ===== logic/hks_housekeeping_adc_scheduler.sv
`timescale 1ns/1ps
`include "hks_regs.svh"
// Functional notes
// RULE_01: Supply background conversions every 8, 2 or 1 minutes per bits 5:4.
// RULE_02: Battery background conversions every 16, 4 or 1 minutes per bits 3:2.
// RULE_03: Temperature background conversions every 8, 2 or 1 minutes per bits 1:0.
// RULE_04: Software keeps interval register bits 7:6 zero; they reset to zero.
// RULE_05: No interval-driven conversion starts while the calendar enable is clear.
// RULE_06: Temperature delta bits 5:3: never, more than N LSBs, or every conversion.
// RULE_07: Supply delta bits 2:0: never, more than N LSBs, or every conversion.
// RULE_08: Background conversions continue in battery active and sleep modes.
// RULE_09: Each single start bit clears once the converter accepts the request.
// RULE_10: A result register updates only when that measurement interrupts; software writes also load it in cycles with no interrupt.
// RULE_11: Finished single conversions always interrupt; no status flag records it.
// RULE_12: Interval timers count calendar minutes and restart when their field is rewritten; the code restarts one only when the written code differs.
module hks_housekeeping_adc_scheduler
    import hks_pkg::*;
#(
    parameter int CHANNELS = 3
) (
    input wire logic core_clk_in, // 250 MHz core clock
    input wire logic sys_rst_in, // Synchronous reset, active high
    input wire logic [7:0] sfr_addr_in, // Register address
    input wire logic sfr_wr_in, // Register write strobe
    input wire logic [7:0] sfr_wdata_in, // Register write data
    input wire logic clock_calendar_enable_in, // Calendar running
    input wire logic minute_tick_in, // One pulse per calendar minute
    input wire logic battery_active_mode_in, // Battery powered active mode
    input wire logic sleep_mode_in, // Core asleep
    input wire logic [2:0] conv_accept_in, // Converter took request, per channel
    input wire logic [2:0] conv_done_in, // Conversion finished, per channel
    input wire logic [7:0] battery_value_in, // Battery converter output
    input wire logic [7:0] temperature_value_in, // Temperature converter output
    input wire logic [7:0] supply_value_in, // Supply converter output
    output logic [7:0] sfr_rdata_out, // Read data, one cycle after address
    output logic [2:0] conv_request_out, // Measurement request, per channel
    output logic adc_irq_out // Shared converter interrupt pulse
);

    // Channel count is fixed by the register layout
    if (CHANNELS != 3) begin : g_bad_channels
        $error("hks_housekeeping_adc_scheduler serves exactly three channels");
    end

    // Interval code to minutes, used for all three timers
    function automatic hks_minutes_t interval_minutes(input int ch, input hks_interval_t sel);
        hks_minutes_t m;
        m = `HKS_MIN_1;
        case (sel)
            2'h1: m = (ch == HKS_CH_BATTERY) ? `HKS_MIN_16 : `HKS_MIN_8;
            2'h2: m = (ch == HKS_CH_BATTERY) ? `HKS_MIN_4 : `HKS_MIN_2;
            default: m = `HKS_MIN_1;
        endcase
        return m;
    endfunction

    // Delta code decision, shared by temperature and supply
    function automatic logic delta_hit(input hks_delta_t sel, input hks_byte_t a, input hks_byte_t b);
        hks_byte_t diff;
        diff = (a > b) ? hks_byte_t'(a - b) : hks_byte_t'(b - a);
        if (sel == `HKS_DELTA_NEVER) begin
            return 1'b0;
        end else if (sel == `HKS_DELTA_ALWAYS) begin
            return 1'b1;
        end
        return diff > {5'h00, sel};
    endfunction

    logic [5:0] interval_q;
    logic [5:0] delta_q;
    logic [2:0] single_start_q;
    logic [2:0] bg_pending_q;
    logic [2:0] was_single_q;
    logic [2:0] strobe;
    logic [2:0] conv_request_q;
    logic adc_irq_q;
    hks_byte_t threshold_q;
    hks_byte_t result_q [3];
    hks_byte_t value [3];
    hks_byte_t sfr_rdata_q;
    logic [2:0] irq_hit;
    logic wr_interval;
    logic wr_start;

    assign value[HKS_CH_BATTERY] = battery_value_in;
    assign value[HKS_CH_TEMPERATURE] = temperature_value_in;
    assign value[HKS_CH_SUPPLY] = supply_value_in;
    assign wr_interval = sfr_wr_in && (sfr_addr_in == `HKS_BACKGROUND_INTERVAL_ADDR);
    assign wr_start = sfr_wr_in && (sfr_addr_in == `HKS_CONVERSION_START_ADDR);

    // Configuration registers; top interval bits are not stored and read zero
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            interval_q <= `HKS_INTERVAL_RESET;
            delta_q <= `HKS_DELTA_RESET;
            threshold_q <= `HKS_BYTE_RESET;
        end else if (sfr_wr_in) begin
            if (sfr_addr_in == `HKS_BACKGROUND_INTERVAL_ADDR) begin
                interval_q <= sfr_wdata_in[5:0]; // see RULE_04
            end
            if (sfr_addr_in == `HKS_CHANGE_DELTA_CONFIG_ADDR) begin
                delta_q <= sfr_wdata_in[5:0];
            end
            if (sfr_addr_in == `HKS_BATTERY_LOW_THRESHOLD_ADDR) begin
                threshold_q <= sfr_wdata_in;
            end
        end
    end

    // Per-channel minute timers; power mode inputs deliberately do not gate them
    for (genvar i = 0; i < 3; i++) begin : g_timer
        // Field of this channel; the fields do not follow channel order
        localparam int FIELD_LSB = (i == HKS_CH_BATTERY) ? `HKS_BATTERY_INTERVAL_LSB
            : (i == HKS_CH_TEMPERATURE) ? `HKS_TEMPERATURE_INTERVAL_LSB : `HKS_SUPPLY_INTERVAL_LSB;
        logic [4:0] minutes_q;
        logic [1:0] old_sel;
        logic [1:0] new_sel;
        logic field_write;
        assign old_sel = interval_q[FIELD_LSB +: 2];
        assign new_sel = sfr_wdata_in[FIELD_LSB +: 2];
        assign field_write = wr_interval && (new_sel != old_sel);
        assign strobe[i] = clock_calendar_enable_in && minute_tick_in && !field_write
            && (old_sel != 2'h0) && (minutes_q + 5'h01 >= interval_minutes(i, old_sel)); // see RULE_05
        always_ff @(posedge core_clk_in) begin
            if (sys_rst_in || field_write) begin
                minutes_q <= 5'h00; // see RULE_12
            end else if (strobe[i]) begin
                minutes_q <= 5'h00; // see RULE_01, see RULE_02, see RULE_03
            end else if (clock_calendar_enable_in && minute_tick_in && old_sel != 2'h0) begin
                minutes_q <= minutes_q + 5'h01; // see RULE_12
            end
        end
    end

    // Single start bits: software sets, converter acceptance clears, a set wins
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            single_start_q <= 3'h0;
        end else begin
            single_start_q <= (single_start_q & ~conv_accept_in) | (wr_start ? sfr_wdata_in[2:0] : 3'h0); // see RULE_09
        end
    end

    // Background requests pend until accepted, in every power mode
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            bg_pending_q <= 3'h0;
        end else begin
            bg_pending_q <= (bg_pending_q & ~conv_accept_in) | strobe; // see RULE_08
        end
    end

    // Request lines and the kind of the accepted request
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            conv_request_q <= 3'h0;
            was_single_q <= 3'h0;
        end else begin
            conv_request_q <= (single_start_q | bg_pending_q | strobe) & ~conv_accept_in;
            for (int i = 0; i < 3; i++) begin
                if (conv_accept_in[i]) begin
                    was_single_q[i] <= single_start_q[i];
                end
            end
        end
    end

    // Interrupt decision per finished conversion
    always_comb begin
        irq_hit[HKS_CH_BATTERY] = conv_done_in[HKS_CH_BATTERY]
            && (was_single_q[HKS_CH_BATTERY] || battery_value_in < threshold_q);
        irq_hit[HKS_CH_TEMPERATURE] = conv_done_in[HKS_CH_TEMPERATURE] && (was_single_q[HKS_CH_TEMPERATURE]
            || delta_hit(delta_q[5:3], temperature_value_in, result_q[HKS_CH_TEMPERATURE])); // see RULE_06, see RULE_11
        irq_hit[HKS_CH_SUPPLY] = conv_done_in[HKS_CH_SUPPLY] && (was_single_q[HKS_CH_SUPPLY]
            || delta_hit(delta_q[2:0], supply_value_in, result_q[HKS_CH_SUPPLY])); // see RULE_07, see RULE_11
    end

    // Results move on an interrupt, or on a software write in a cycle with no interrupt
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < 3; i++) begin
                result_q[i] <= `HKS_BYTE_RESET;
            end
            adc_irq_q <= 1'b0;
        end else begin
            adc_irq_q <= |irq_hit; // see RULE_11
            for (int i = 0; i < 3; i++) begin
                if (irq_hit[i]) begin
                    result_q[i] <= value[i]; // see RULE_10
                end
            end
            if (sfr_wr_in && irq_hit == 3'h0) begin
                case (sfr_addr_in)
                    `HKS_BATTERY_RESULT_ADDR: result_q[HKS_CH_BATTERY] <= sfr_wdata_in;
                    `HKS_TEMPERATURE_RESULT_ADDR: result_q[HKS_CH_TEMPERATURE] <= sfr_wdata_in;
                    `HKS_SUPPLY_RESULT_ADDR: result_q[HKS_CH_SUPPLY] <= sfr_wdata_in;
                    default: ;
                endcase
            end
        end
    end

    // Registered read port; unmapped addresses read zero
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            sfr_rdata_q <= `HKS_BYTE_RESET;
        end else begin
            case (sfr_addr_in)
                `HKS_TEMPERATURE_RESULT_ADDR: sfr_rdata_q <= result_q[HKS_CH_TEMPERATURE];
                `HKS_CONVERSION_START_ADDR: sfr_rdata_q <= {5'h00, single_start_q};
                `HKS_BATTERY_RESULT_ADDR: sfr_rdata_q <= result_q[HKS_CH_BATTERY];
                `HKS_SUPPLY_RESULT_ADDR: sfr_rdata_q <= result_q[HKS_CH_SUPPLY];
                `HKS_CHANGE_DELTA_CONFIG_ADDR: sfr_rdata_q <= {2'h0, delta_q};
                `HKS_BACKGROUND_INTERVAL_ADDR: sfr_rdata_q <= {2'h0, interval_q}; // see RULE_04
                `HKS_BATTERY_LOW_THRESHOLD_ADDR: sfr_rdata_q <= threshold_q;
                default: sfr_rdata_q <= `HKS_BYTE_RESET;
            endcase
        end
    end

    assign sfr_rdata_out = sfr_rdata_q;
    assign conv_request_out = conv_request_q;
    assign adc_irq_out = adc_irq_q;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_tick_when_stopped;
        !clock_calendar_enable_in ##0 minute_tick_in;
    endsequence

    sequence s_accept_no_set(int i);
        conv_accept_in[i] && !(wr_start && sfr_wdata_in[i]);
    endsequence

    sequence s_live_tick;
        clock_calendar_enable_in && minute_tick_in && !wr_interval;
    endsequence

    sequence s_single_done(int i);
        conv_done_in[i] && was_single_q[i];
    endsequence

    a_strobe_gated: assert property (strobe != 3'h0 |-> clock_calendar_enable_in && minute_tick_in) // see RULE_05
        else $error("background strobe without running calendar");
    a_stopped_no_bg: assert property (s_tick_when_stopped |=> (bg_pending_q & ~$past(bg_pending_q)) == 3'h0) // see RULE_05
        else $error("background request raised while calendar stopped");
    a_temp_go_clear: assert property (s_accept_no_set(1) |=> !single_start_q[1]) // see RULE_09
        else $error("temperature start bit did not clear on acceptance");
    a_supply_go_clear: assert property (s_accept_no_set(2) |=> !single_start_q[2]) // see RULE_09
        else $error("supply start bit did not clear on acceptance");
    a_result_on_irq: assert property (!$past(sfr_wr_in) && $changed(result_q[1]) |-> adc_irq_q) // see RULE_10
        else $error("temperature result moved without an interrupt");
    a_single_irq: assert property (conv_done_in[2] && was_single_q[2] |=> adc_irq_q) // see RULE_11
        else $error("finished single supply conversion did not interrupt");
    a_temp_never: assert property (delta_q[5:3] == 3'h0 && !was_single_q[1] && conv_done_in[1] |-> !irq_hit[1]) // see RULE_06
        else $error("temperature interrupt with delta code never");
    a_supply_every: assert property (delta_q[2:0] == 3'h7 && conv_done_in[2] |=> adc_irq_q) // see RULE_07
        else $error("supply conversion did not interrupt with delta code every");
    a_temp_one_min: assert property (interval_q[1:0] == 2'h3 && clock_calendar_enable_in && minute_tick_in
        && !wr_interval |-> strobe[1]) // see RULE_03
        else $error("one minute temperature interval missed a strobe");
    a_top_bits_zero: assert property (sfr_addr_in == 8'hF9 |=> sfr_rdata_q[7:6] == 2'h0) // see RULE_04
        else $error("interval register top bits not zero");
    a_mode_free: assert property ((battery_active_mode_in || sleep_mode_in) && interval_q[3:2] == 2'h3 // see RULE_08
        && clock_calendar_enable_in && minute_tick_in && !wr_interval |-> strobe[0])
        else $error("battery one minute strobe lost in a low power mode");

    // Period boundaries: a strobe lands on the last minute of its period
    a_supply_one_min: assert property (s_live_tick ##0 interval_q[5:4] == 2'h3 |-> strobe[2]) // see RULE_01
        else $error("one minute supply interval missed a strobe");
    a_supply_eight: assert property (interval_q[5:4] == 2'h1 && strobe[2] // see RULE_01
        |-> g_timer[2].minutes_q == 5'h07)
        else $error("eight minute supply strobe off its boundary");
    a_supply_off: assert property (interval_q[5:4] == 2'h0 |-> !strobe[2]) // see RULE_01
        else $error("supply strobe with its interval off");
    a_batt_sixteen: assert property (interval_q[3:2] == 2'h1 && strobe[0] // see RULE_02
        |-> g_timer[0].minutes_q == 5'h0F)
        else $error("sixteen minute battery strobe off its boundary");
    a_batt_four: assert property (interval_q[3:2] == 2'h2 && strobe[0] // see RULE_02
        |-> g_timer[0].minutes_q == 5'h03)
        else $error("four minute battery strobe off its boundary");
    a_batt_off: assert property (interval_q[3:2] == 2'h0 |-> !strobe[0]) // see RULE_02
        else $error("battery strobe with its interval off");
    a_temp_two: assert property (interval_q[1:0] == 2'h2 && strobe[1] // see RULE_03
        |-> g_timer[1].minutes_q == 5'h01)
        else $error("two minute temperature strobe off its boundary");
    a_timer_restart: assert property (wr_interval && sfr_wdata_in[1:0] != interval_q[1:0] // see RULE_12
        |=> g_timer[1].minutes_q == 5'h00)
        else $error("temperature timer kept counting after its field changed");

    // Start bits, request lines and interrupt causes
    a_batt_go_clear: assert property (s_accept_no_set(0) |=> !single_start_q[0]) // see RULE_09
        else $error("battery start bit did not clear on acceptance");
    a_req_drop: assert property (conv_accept_in != 3'h0 // see RULE_09
        |=> (conv_request_q & $past(conv_accept_in)) == 3'h0)
        else $error("request still raised after acceptance");
    a_batt_single_irq: assert property (s_single_done(0) |=> adc_irq_q) // see RULE_11
        else $error("finished single battery conversion did not interrupt");
    a_temp_single_irq: assert property (s_single_done(1) |=> adc_irq_q) // see RULE_11
        else $error("finished single temperature conversion did not interrupt");
    a_irq_cause: assert property (adc_irq_q |-> $past(conv_done_in) != 3'h0) // see RULE_11
        else $error("interrupt without a finished conversion");
    a_supply_never: assert property (delta_q[2:0] == 3'h0 && !was_single_q[2] && conv_done_in[2] // see RULE_07
        |-> !irq_hit[2])
        else $error("supply interrupt with delta code never");
    a_temp_every: assert property (delta_q[5:3] == 3'h7 && conv_done_in[1] |=> adc_irq_q) // see RULE_06
        else $error("temperature conversion did not interrupt with delta code every");
    a_supply_result: assert property (!$past(sfr_wr_in) && $changed(result_q[2]) // see RULE_10
        |-> adc_irq_q)
        else $error("supply result moved without an interrupt");

endmodule

// ===== logic/hks_regs.svh
`ifndef HKS_REGS_SVH
`define HKS_REGS_SVH

// Register offsets on the special function register bus
`define HKS_TEMPERATURE_RESULT_ADDR 8'hD7
`define HKS_CONVERSION_START_ADDR 8'hD8
`define HKS_BATTERY_RESULT_ADDR 8'hDF
`define HKS_SUPPLY_RESULT_ADDR 8'hEF
`define HKS_CHANGE_DELTA_CONFIG_ADDR 8'hF3
`define HKS_BACKGROUND_INTERVAL_ADDR 8'hF9
`define HKS_BATTERY_LOW_THRESHOLD_ADDR 8'hFA

// Field positions: background_interval
`define HKS_SUPPLY_INTERVAL_LSB 4
`define HKS_BATTERY_INTERVAL_LSB 2
`define HKS_TEMPERATURE_INTERVAL_LSB 0
// Field positions: change_delta_config
`define HKS_TEMPERATURE_DELTA_LSB 3
`define HKS_SUPPLY_DELTA_LSB 0
// Field positions: conversion_start
`define HKS_BATTERY_START_BIT 0
`define HKS_TEMPERATURE_START_BIT 1
`define HKS_SUPPLY_START_BIT 2

// Reset values
`define HKS_BYTE_RESET 8'h00
`define HKS_INTERVAL_RESET 6'h00
`define HKS_DELTA_RESET 6'h00

// Delta codes
`define HKS_DELTA_NEVER 3'h0
`define HKS_DELTA_ALWAYS 3'h7

// Interval lengths in minutes
`define HKS_MIN_8 5'h08
`define HKS_MIN_2 5'h02
`define HKS_MIN_1 5'h01
`define HKS_MIN_16 5'h10
`define HKS_MIN_4 5'h04

`endif

// ===== logic/hks_pkg.sv
package hks_pkg;
    // Converter channel index, matching the start bit order
    typedef enum logic [1:0] {
        HKS_CH_BATTERY,
        HKS_CH_TEMPERATURE,
        HKS_CH_SUPPLY
    } hks_chan_e;
    typedef logic [7:0] hks_byte_t;
    typedef logic [1:0] hks_interval_t;
    typedef logic [2:0] hks_delta_t;
    typedef logic [4:0] hks_minutes_t;
endpackage

// ===== verification/hks_conv_model.sv
`timescale 1ns/1ps
// Behavioural converters; DLY sets how slowly each one answers
module hks_conv_model #(parameter int DLY = 3) (
    input wire logic core_clk_in, // Core clock
    input wire logic [2:0] conv_request_in, // Requests per channel
    input wire logic [23:0] next_value_in, // Results to hand back
    output logic [2:0] conv_accept_out, // Request taken
    output logic [2:0] conv_done_out, // Result ready
    output logic [23:0] value_out, // Meaningful with done only
    output logic busy_out // Some conversion running
);
    logic [2:0] busy = 3'h0;
    assign busy_out = |busy;
    // Lines start quiet
    initial {conv_accept_out, conv_done_out, value_out} = 30'h00000000;
    // Accept after DLY edges, finish later; done never comes before accept
    for (genvar c = 0; c < 3; c++) begin : g_ch
        always begin
            @(posedge core_clk_in);
            if (conv_request_in[c] === 1'b1) begin
                busy[c] = 1'b1;
                repeat (DLY) @(posedge core_clk_in);
                #1 conv_accept_out[c] = 1'b1;
                @(posedge core_clk_in);
                #1 conv_accept_out[c] = 1'b0;
                repeat (DLY + 2) @(posedge core_clk_in);
                #1 conv_done_out[c] = 1'b1;
                value_out[c*8 +: 8] = next_value_in[c*8 +: 8];
                @(posedge core_clk_in);
                // Released lines show the inverse, so a stale copy cannot pass
                #1 conv_done_out[c] = 1'b0;
                value_out[c*8 +: 8] = ~value_out[c*8 +: 8];
                busy[c] = 1'b0;
            end
        end
    end
endmodule

// ===== verification/test_housekeeping_adc_scheduler.sv
`timescale 1ns/1ps
`include "hks_regs.svh"
module test_housekeeping_adc_scheduler;
    import hks_pkg::*;
    // Channel, config byte, prior result, new value, interrupt expected
    typedef struct packed {hks_chan_e ch; hks_byte_t cfg, prev, nv; logic irq;} hks_row_s;
    logic clk, rst, wr_en, en, tick, bat_mode, sleep, irq, busy;
    logic [7:0] addr, wdata, rdata;
    logic [2:0] acc, done, req, req_d;
    logic [23:0] nxt, mv;
    int n_fail = 0;
    int n_checks = 0;
    int n_irq = 0;
    int n_req [3] = '{0, 0, 0};
    hks_byte_t res_at [3] = '{`HKS_BATTERY_RESULT_ADDR, `HKS_TEMPERATURE_RESULT_ADDR, `HKS_SUPPLY_RESULT_ADDR};
    int ivl_at [3] = '{`HKS_BATTERY_INTERVAL_LSB, `HKS_TEMPERATURE_INTERVAL_LSB, `HKS_SUPPLY_INTERVAL_LSB};
    hks_byte_t addrs [8] = '{`HKS_TEMPERATURE_RESULT_ADDR, `HKS_BATTERY_RESULT_ADDR, `HKS_SUPPLY_RESULT_ADDR,
        `HKS_CHANGE_DELTA_CONFIG_ADDR, `HKS_BACKGROUND_INTERVAL_ADDR, `HKS_BATTERY_LOW_THRESHOLD_ADDR, 8'h80,
        `HKS_CONVERSION_START_ADDR};
    hks_row_s rows [10] = '{
        '{HKS_CH_SUPPLY, 8'h00, 8'h0A, 8'h32, 1'b0},
        '{HKS_CH_SUPPLY, 8'h07, 8'h0A, 8'h0A, 1'b1},
        '{HKS_CH_SUPPLY, 8'h03, 8'h0A, 8'h0D, 1'b0},
        '{HKS_CH_SUPPLY, 8'h03, 8'h0A, 8'h0E, 1'b1},
        '{HKS_CH_SUPPLY, 8'h03, 8'h14, 8'h10, 1'b1},
        '{HKS_CH_TEMPERATURE, 8'h30, 8'h64, 8'h6A, 1'b0},
        '{HKS_CH_TEMPERATURE, 8'h30, 8'h64, 8'h5D, 1'b1},
        '{HKS_CH_TEMPERATURE, 8'h38, 8'h64, 8'h64, 1'b1},
        '{HKS_CH_BATTERY, 8'h40, 8'h22, 8'h3F, 1'b1},
        '{HKS_CH_BATTERY, 8'h40, 8'h22, 8'h40, 1'b0}};
    hks_housekeeping_adc_scheduler #(.CHANNELS(3)) uut (.core_clk_in(clk), .sys_rst_in(rst), .sfr_addr_in(addr),
        .sfr_wr_in(wr_en), .sfr_wdata_in(wdata), .clock_calendar_enable_in(en), .minute_tick_in(tick),
        .battery_active_mode_in(bat_mode), .sleep_mode_in(sleep), .conv_accept_in(acc), .conv_done_in(done),
        .battery_value_in(mv[7:0]), .temperature_value_in(mv[15:8]), .supply_value_in(mv[23:16]),
        .sfr_rdata_out(rdata), .conv_request_out(req), .adc_irq_out(irq));
    hks_conv_model #(.DLY(3)) conv (.core_clk_in(clk), .conv_request_in(req), .next_value_in(nxt),
        .conv_accept_out(acc), .conv_done_out(done), .value_out(mv), .busy_out(busy));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Count interrupt pulses and fresh requests; pulses last one cycle
    always @(posedge clk) begin
        if (irq === 1'b1) n_irq++;
        for (int c = 0; c < 3; c++) if (req[c] === 1'b1 && req_d[c] !== 1'b1) n_req[c]++;
        req_d = req;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input hks_byte_t a, input hks_byte_t d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(posedge clk);
        #1 wr_en = 1'b0;
        // One quiet edge, so a following write never re-raises the strobe at once
        @(posedge clk);
        #1;
    endtask
    // Read data is registered, so look one edge after the address
    task automatic rd(input hks_byte_t a, input hks_byte_t exp);
        addr = a;
        @(posedge clk);
        #1 chk(rdata, exp);
    endtask
    // Bounded wait for idle converters, then let result and pulse land
    task automatic settle;
        int k;
        repeat (4) @(posedge clk);
        for (k = 0; k < 60 && busy === 1'b1; k++) @(posedge clk);
        if (k == 60) begin
            n_fail++;
            conclude();
        end
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic minute;
        tick = 1'b1;
        @(posedge clk);
        #1 tick = 1'b0;
        settle();
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        hks_row_s r;
        int ms;
        {rst, wr_en, tick, bat_mode, sleep} = 5'b10000;
        en = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        nxt = 24'h000000;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        // Table of background conversions against delta and threshold settings
        foreach (rows[i]) begin
            r = rows[i];
            wr(r.ch == HKS_CH_BATTERY ? `HKS_BATTERY_LOW_THRESHOLD_ADDR : `HKS_CHANGE_DELTA_CONFIG_ADDR, r.cfg);
            wr(res_at[r.ch], r.prev);
            wr(`HKS_BACKGROUND_INTERVAL_ADDR, 8'(8'h03 << ivl_at[r.ch]));
            nxt[r.ch*8 +: 8] = r.nv;
            n_irq = 0;
            minute();
            chk(8'(n_irq), {7'h00, r.irq});
            rd(res_at[r.ch], r.irq ? r.nv : r.prev);
        end
        $display("test delta rows done");
        // Interval codes 1 to 3 on all channels; power modes must not gate them
        for (int code = 1; code <= 3; code++) begin
            wr(`HKS_BACKGROUND_INTERVAL_ADDR, 8'h00);
            wr(`HKS_BACKGROUND_INTERVAL_ADDR, 8'(8'h15 * code));
            bat_mode = code == 3;
            sleep = code >= 2;
            n_req = '{0, 0, 0};
            repeat (16) minute();
            ms = code == 1 ? 8 : code == 2 ? 2 : 1;
            chk(8'(n_req[2]), 8'(16 / ms));
            chk(8'(n_req[1]), 8'(16 / ms));
            chk(8'(n_req[0]), 8'(code == 1 ? 1 : code == 2 ? 4 : 16));
        end
        $display("test intervals done");
        // A new code mid-count restarts it, so no strobe on the next tick
        wr(`HKS_BACKGROUND_INTERVAL_ADDR, 8'h02);
        minute();
        wr(`HKS_BACKGROUND_INTERVAL_ADDR, 8'h03);
        wr(`HKS_BACKGROUND_INTERVAL_ADDR, 8'h02);
        n_req = '{0, 0, 0};
        minute();
        chk(8'(n_req[1]), 8'h00);
        minute();
        chk(8'(n_req[1]), 8'h01);
        en = 1'b0;
        wr(`HKS_BACKGROUND_INTERVAL_ADDR, 8'h3F);
        n_req = '{0, 0, 0};
        repeat (3) minute();
        chk(8'(n_req[0] + n_req[1] + n_req[2]), 8'h00);
        $display("test restart and enable done");
        // Single starts interrupt even with all change criteria off
        wr(`HKS_BACKGROUND_INTERVAL_ADDR, 8'h00);
        wr(`HKS_CHANGE_DELTA_CONFIG_ADDR, 8'h00);
        wr(`HKS_BATTERY_LOW_THRESHOLD_ADDR, 8'h00);
        nxt = 24'hC35AE1;
        for (int c = 0; c < 3; c++) begin
            n_irq = 0;
            wr(`HKS_CONVERSION_START_ADDR, 8'(8'h01 << c));
            rd(`HKS_CONVERSION_START_ADDR, 8'(8'h01 << c));
            settle();
            rd(`HKS_CONVERSION_START_ADDR, 8'h00);
            chk(8'(n_irq), 8'h01);
            rd(res_at[c], nxt[c*8 +: 8]);
        end
        $display("test single starts done");
        // Stored registers, an unmapped place, then a reset in mid-run
        for (int i = 0; i < 7; i++) begin
            wr(addrs[i], 8'h2A);
            rd(addrs[i], i == 6 ? 8'h00 : 8'h2A);
        end
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        $display("test registers and reset done");
        conclude();
    end
endmodule
